// ### verilog/rsq_reset_seq.sv
// Reset sequencer top: pin sampling, reset procedure, release timing.
// Assumes all pins are asynchronous to clock_i and the oscillators
// arrive as pins that are sampled here.
//
// Overview of operation
// R1: Reset pin held low two machine cycles
// R2: Reset on second low sample, repeated
// R3: Strobe pins are inputs during reset
// R4: Fetch starts at address zero
// R5: Boot select pin picks start mode
// R6: Port latches 0 to 6 load all ones
// R7: Input-only ports read live pin levels
// R8: Reset leaves internal RAM untouched
// R9: Reset pin sampled once at S5P2
// R10: Two machine cycles reach default state
// R11: No clock means no reset procedure
// R12: Stay in reset while pin low
// R13: Release at S5P2, address S5P1, strobe
// R14: RC faster than main flags failure
// R15: Hold reset 768 RC cycles, then switch
// R16: Execution waits for external reset release
// R17: External reset ends powerdown, clears flag
// R18: Partner holds reset through oscillator start
// R19: Reset output pin shows internal reset
// R20: Six states, two phases, half rate
module rsq_reset_seq
   import rsq_pkg::*;
(
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   // Device pins
   input  wire logic        reset_pin_n_i,
   input  wire logic        boot_mode_select_i,
   input  wire logic        hw_powerdown_input_n_i,
   input  wire logic        rc_osc_i,
   input  wire logic        main_osc_i,
   input  wire logic [7:0]  port7_pin_i,
   input  wire logic [7:0]  port8_pin_i,
   // Core requests
   input  wire logic [6:0]  port_wr_i,
   input  wire logic [7:0]  port_wr_data_i,
   input  wire logic        ram_wr_i,
   // Reset and start outputs
   output logic             internal_reset_o,
   output logic             reset_output_pin_n_o,
   output logic             run_o,
   output logic [15:0]      fetch_addr_o,
   output logic             fetch_start_o,
   output logic             addr_out_en_o,
   output logic             boot_mode_o,
   // Strobe pins
   output logic             ale_o,
   output logic             ale_oe_o,
   output logic             program_store_enable_oe_o,
   // Ports and memory
   output logic [55:0]      port_latch_o,
   output logic [7:0]       port7_rd_o,
   output logic [7:0]       port8_rd_o,
   output logic             ram_wr_en_o,
   // Power and watchdog status
   output logic             hw_powerdown_o,
   output logic             sw_powerdown_exit_o,
   output logic             osc_watchdog_status_flag_o,
   output logic             osc_fail_o
);
   typedef enum logic [1:0] {
      SEQ_RUN,
      SEQ_ARM,
      SEQ_RESET,
      SEQ_WAIT
   } rsq_seq_type;

   typedef struct packed {
      logic [SY_W-1:0]                         sy1;
      logic [SY_W-1:0]                         sy2;
      logic [1:0]                              edg;
      rsq_seq_type                             seq;
      logic [1:0]                              mcyc;
      logic [NUM_LATCH_PORTS-1:0][PORT_W-1:0]  latch;
      logic                                    fetch_start;
      logic                                    ale;
      logic                                    boot;
      logic                                    osc_watchdog_status_flag;
      logic                                    run;
   } rsq_main_state_type;

   rsq_main_state_type q_ff, nxt_q;

   logic rc_tick;
   logic main_tick;
   logic src_tick;
   logic phase_en;
   logic s5p1;
   logic s5p2;
   logic owd_req;
   logic owd_fail;
   logic owd_fail_set;
   logic ext_low;
   logic in_reset;

   // ==========================================================
   // Pin sampling and oscillator edges
   assign ext_low   = ~q_ff.sy2[SY_RST];
   assign rc_tick   = q_ff.sy2[SY_RC] & ~q_ff.edg[0];
   assign main_tick = q_ff.sy2[SY_MAIN] & ~q_ff.edg[1];
   assign in_reset  = (q_ff.seq == SEQ_RESET);

   // ==========================================================
   // Oscillator watchdog and clock source
   rsq_osc_watchdog u_owd (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .rc_tick_i   (rc_tick),
      .main_tick_i (main_tick),
      .src_tick_o  (src_tick),
      .fail_o      (owd_fail),
      .fail_set_o  (owd_fail_set),
      .owd_req_o   (owd_req)
   );

   // ==========================================================
   // Machine cycle timing, advanced only by a live clock source
   rsq_phase_gen u_phase (
      .clock_i    (clock_i),
      .rst_n_i    (rst_n_i),
      .src_tick_i (src_tick),                             // R11
      .phase_en_o (phase_en),
      .s5p1_o     (s5p1),
      .s5p2_o     (s5p2)
   );

   // ==========================================================
   // Sequencer
   always_comb begin
      nxt_q             = q_ff;
      nxt_q.sy1         = {port8_pin_i, port7_pin_i, main_osc_i,
                           rc_osc_i, hw_powerdown_input_n_i,
                           boot_mode_select_i, reset_pin_n_i};
      nxt_q.sy2         = q_ff.sy1;
      nxt_q.edg         = {q_ff.sy2[SY_MAIN], q_ff.sy2[SY_RC]};
      nxt_q.fetch_start = 1'b0;
      if (s5p2) begin                                     // R9
         case (q_ff.seq)
            SEQ_RUN: begin
               if (ext_low) begin
                  nxt_q.seq = SEQ_ARM;
               end else if (owd_req) begin
                  nxt_q.seq  = SEQ_RESET;
                  nxt_q.mcyc = 2'h0;
               end
            end
            SEQ_ARM: begin
               if (ext_low) begin                         // R2
                  nxt_q.seq  = SEQ_RESET;
                  nxt_q.mcyc = 2'h0;
                  nxt_q.osc_watchdog_status_flag = 1'b0;                      // R17
               end else if (owd_req) begin
                  nxt_q.seq  = SEQ_RESET;
                  nxt_q.mcyc = 2'h0;
               end else begin
                  nxt_q.seq = SEQ_RUN;
               end
            end
            SEQ_RESET: begin
               if (ext_low) begin
                  nxt_q.osc_watchdog_status_flag = 1'b0;                      // R17
               end
               if (q_ff.mcyc != MIN_RESET_MCYC) begin     // R10
                  nxt_q.mcyc = q_ff.mcyc + 2'h1;
               end else if (!ext_low && !owd_req) begin   // R12 R16
                  nxt_q.seq = SEQ_WAIT;                   // R13
               end
            end
            SEQ_WAIT: begin
               nxt_q.seq = SEQ_WAIT;
            end
            default: begin
               nxt_q.seq = SEQ_RESET;
            end
         endcase
         if (q_ff.ale) begin
            nxt_q.ale = 1'b0;                             // R13
         end
      end
      if (s5p1 && q_ff.seq == SEQ_WAIT) begin
         nxt_q.seq         = SEQ_RUN;                     // R13
         nxt_q.run         = 1'b1;
         nxt_q.fetch_start = 1'b1;                        // R4
         nxt_q.ale         = 1'b1;
         nxt_q.boot        = q_ff.sy2[SY_BOOT];           // R5
      end
      if (nxt_q.seq == SEQ_RESET) begin
         nxt_q.run = 1'b0;                                // R16
         nxt_q.ale = 1'b0;
      end
      for (int i = 0; i < NUM_LATCH_PORTS; i++) begin
         if (in_reset) begin
            nxt_q.latch[i] = PORT_LATCH_RST;              // R6 R10
         end else if (port_wr_i[i]) begin
            nxt_q.latch[i] = port_wr_data_i;
         end
      end
      if (owd_fail_set) begin
         nxt_q.osc_watchdog_status_flag = 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_ff       <= '0;
         q_ff.seq   <= SEQ_RESET;
         q_ff.latch <= {NUM_LATCH_PORTS{PORT_LATCH_RST}};
         q_ff.osc_watchdog_status_flag  <= 1'b1;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // ==========================================================
   // Outputs
   assign internal_reset_o           = in_reset;          // R2
   assign reset_output_pin_n_o       = ~in_reset;         // R19
   assign run_o                      = q_ff.run;
   assign fetch_addr_o               = RESET_VECTOR;      // R4
   assign fetch_start_o              = q_ff.fetch_start;
   assign addr_out_en_o              = q_ff.run;          // R13
   assign boot_mode_o                = q_ff.boot;
   assign ale_o                      = q_ff.ale;
   assign ale_oe_o                   = q_ff.run;          // R3
   assign program_store_enable_oe_o  = q_ff.run;          // R3
   assign port_latch_o               = q_ff.latch;
   assign port7_rd_o                 = q_ff.sy2[SY_P7 +: 8]; // R7
   assign port8_rd_o                 = q_ff.sy2[SY_P8 +: 8]; // R7
   assign ram_wr_en_o                = ram_wr_i & q_ff.run; // R8
   assign hw_powerdown_o = ~q_ff.sy2[SY_HW_POWERDOWN_INPUT] & ~in_reset; // R17
   assign sw_powerdown_exit_o        = in_reset;          // R17
   assign osc_watchdog_status_flag_o = q_ff.osc_watchdog_status_flag;
   assign osc_fail_o                 = owd_fail;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_first_low_arms;
      s5p2 && q_ff.seq == SEQ_RUN && ext_low |=> q_ff.seq == SEQ_ARM;
   endproperty
   a_first_low_arms: assert property (p_first_low_arms) // R9
      else $error("first low sample did not arm reset");

   property p_second_low_resets;
      s5p2 && q_ff.seq == SEQ_ARM && ext_low
         |=> internal_reset_o && !reset_output_pin_n_o;
   endproperty
   a_second_low_resets: assert property (p_second_low_resets) // R2
      else $error("second low sample did not reset");

   property p_min_cycles;
      s5p2 && in_reset && q_ff.mcyc != MIN_RESET_MCYC |=> in_reset;
   endproperty
   a_min_cycles: assert property (p_min_cycles) // R10
      else $error("reset left before two machine cycles");

   property p_hold_while_low;
      s5p2 && in_reset && (ext_low || owd_req) |=> in_reset;
   endproperty
   a_hold_while_low: assert property (p_hold_while_low) // R12
      else $error("reset released while a request was active");

   property p_latches_set;
      in_reset |=> port_latch_o == {NUM_LATCH_PORTS{PORT_LATCH_RST}};
   endproperty
   a_latches_set: assert property (p_latches_set) // R6
      else $error("port latches not all ones after reset");

   property p_strobes_input;
      !run_o |-> !ale_oe_o && !program_store_enable_oe_o && !ram_wr_en_o;
   endproperty
   a_strobes_input: assert property (p_strobes_input) // R3
      else $error("strobe pin driven or RAM written in reset");

   property p_release_timing;
      s5p1 && q_ff.seq == SEQ_WAIT
         |=> run_o && fetch_start_o && ale_o ##1 !fetch_start_o;
   endproperty
   a_release_timing: assert property (p_release_timing) // R13
      else $error("address output did not start at S5P1");

   property p_ale_falls;
      ale_o && s5p2 |=> !ale_o;
   endproperty
   a_ale_falls: assert property (p_ale_falls) // R13
      else $error("strobe did not fall at S5P2");

   property p_input_ports;
      $past(rst_n_i, 2) |-> port7_rd_o == $past(port7_pin_i, 2);
   endproperty
   a_input_ports: assert property (p_input_ports) // R7
      else $error("input-only port read not tracking pins");

   property p_osc_watchdog_status_flag_set;
      owd_fail_set |=> osc_watchdog_status_flag_o;
   endproperty
   a_osc_watchdog_status_flag_set: assert property (p_osc_watchdog_status_flag_set) // R14
      else $error("watchdog status flag not set on failure");

   property p_osc_watchdog_status_flag_cleared;
      s5p2 && (in_reset || q_ff.seq == SEQ_ARM) && ext_low && !owd_fail_set
         |=> !osc_watchdog_status_flag_o;
   endproperty
   a_osc_watchdog_status_flag_cleared: assert property (p_osc_watchdog_status_flag_cleared) // R17
      else $error("external reset did not clear watchdog status flag");

   property p_port8_live;
      $past(rst_n_i, 2) |-> port8_rd_o == $past(port8_pin_i, 2);
   endproperty
   a_port8_live: assert property (p_port8_live) // R7
      else $error("second input-only port read not tracking pins");

   property p_owd_forces_reset;
      s5p2 && q_ff.seq == SEQ_RUN && !ext_low && owd_req
         |=> !reset_output_pin_n_o;
   endproperty
   a_owd_forces_reset: assert property (p_owd_forces_reset) // R19
      else $error("watchdog request not shown on reset output");

   property p_no_run_in_reset;
      internal_reset_o |-> !run_o && !addr_out_en_o;
   endproperty
   a_no_run_in_reset: assert property (p_no_run_in_reset) // R16
      else $error("execution active during reset");

   property p_boot_capture;
      s5p1 && q_ff.seq == SEQ_WAIT
         |=> boot_mode_o == $past(q_ff.sy2[SY_BOOT]);
   endproperty
   a_boot_capture: assert property (p_boot_capture) // R5
      else $error("boot level not captured at release");

   property p_hw_powerdown_input_override;
      internal_reset_o |-> !hw_powerdown_o && sw_powerdown_exit_o;
   endproperty
   a_hw_powerdown_input_override: assert property (p_hw_powerdown_input_override) // R17
      else $error("power-down not ended by reset");

   c_release: cover property (s5p1 && q_ff.seq == SEQ_WAIT);
   c_ext_reset: cover property (s5p2 && q_ff.seq == SEQ_ARM && ext_low);
   c_ale_fall: cover property (ale_o && s5p2);
endmodule // rsq_reset_seq

// ### verilog/rsq_pkg.sv
// Shared constants for the reset and power-on sequencer.
// Assumes one system clock; all other clocks arrive as sampled pins.
package rsq_pkg;
   // ==========================================================
   // Machine cycle timing
   localparam logic [2:0] ST_IDX_S5    = 3'h4;
   localparam logic [2:0] ST_IDX_LAST  = 3'h5;
   localparam logic [2:0] ST_IDX_FIRST = 3'h0;
   localparam logic       PH_1         = 1'b0;
   localparam logic       PH_2         = 1'b1;
   localparam logic [1:0] MIN_RESET_MCYC = 2'h2;
   // ==========================================================
   // Oscillator watchdog
   localparam logic [9:0] RC_STABLE_CYCLES = 10'h300;
   // ==========================================================
   // Reset values
   localparam int unsigned NUM_LATCH_PORTS = 7;
   localparam int unsigned PORT_W          = 8;
   localparam logic [7:0]  PORT_LATCH_RST  = 8'hff;
   localparam logic [15:0] RESET_VECTOR    = 16'h0000;
   // ==========================================================
   // Pin synchroniser bit positions
   localparam int unsigned SY_RST  = 0;
   localparam int unsigned SY_BOOT = 1;
   localparam int unsigned SY_HW_POWERDOWN_INPUT = 2;
   localparam int unsigned SY_RC   = 3;
   localparam int unsigned SY_MAIN = 4;
   localparam int unsigned SY_P7   = 5;
   localparam int unsigned SY_P8   = 13;
   localparam int unsigned SY_W    = 21;
endpackage

// ### verilog/rsq_phase_gen.sv
// Machine cycle state and phase counter.
// Assumes src_tick_i is a one-cycle pulse per chip oscillator period.
module rsq_phase_gen
   import rsq_pkg::*;
(
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   // Oscillator tick
   input  wire logic src_tick_i,
   // Position strobes
   output logic      phase_en_o,
   output logic      s5p1_o,
   output logic      s5p2_o
);
   typedef struct packed {
      logic       div;
      logic [2:0] st;
      logic       ph;
      logic       en;
   } rsq_phase_state_type;

   rsq_phase_state_type q_ff, nxt_q;

   // ==========================================================
   // Half rate divider and counters
   always_comb begin
      nxt_q    = q_ff;
      nxt_q.en = 1'b0;
      if (src_tick_i) begin
         nxt_q.div = ~q_ff.div;
         if (q_ff.div) begin                              // R20
            nxt_q.en = 1'b1;
            if (q_ff.ph == PH_2) begin
               nxt_q.ph = PH_1;
               nxt_q.st = (q_ff.st == ST_IDX_LAST) ? ST_IDX_FIRST
                                                   : q_ff.st + 3'h1;
            end else begin
               nxt_q.ph = PH_2;
            end
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_ff <= '{div: 1'b0, st: ST_IDX_FIRST, ph: PH_1, en: 1'b0};
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign phase_en_o = q_ff.en;
   assign s5p1_o = q_ff.en && q_ff.st == ST_IDX_S5 && q_ff.ph == PH_1;
   assign s5p2_o = q_ff.en && q_ff.st == ST_IDX_S5 && q_ff.ph == PH_2;

   // ==========================================================
   // Checks
   property p_phase_half_rate;
      @(posedge clock_i) disable iff (!rst_n_i)
      q_ff.en |=> !q_ff.en;
   endproperty
   a_phase_half_rate: assert property (p_phase_half_rate) // R20
      else $error("phase enable ran at full oscillator rate");
endmodule // rsq_phase_gen

// ### verilog/rsq_osc_watchdog.sv
// Oscillator watchdog: compares RC and main oscillator ticks.
// Assumes both ticks are synchronised one-cycle pulses.
module rsq_osc_watchdog
   import rsq_pkg::*;
(
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   // Oscillator ticks
   input  wire logic rc_tick_i,
   input  wire logic main_tick_i,
   // Status
   output logic      src_tick_o,
   output logic      fail_o,
   output logic      fail_set_o,
   output logic      owd_req_o
);
   typedef struct packed {
      logic [1:0] main_cnt;
      logic       fail;
      logic       req;
      logic       use_rc;
      logic [9:0] stab;
      logic       fail_set;
   } rsq_owd_state_type;

   rsq_owd_state_type q_ff, nxt_q;

   // ==========================================================
   // Failure detection and stabilisation hold
   always_comb begin
      nxt_q          = q_ff;
      nxt_q.fail_set = 1'b0;
      if (main_tick_i && q_ff.main_cnt != 2'h3) begin
         nxt_q.main_cnt = q_ff.main_cnt + 2'h1;
      end
      if (rc_tick_i) begin
         nxt_q.main_cnt = 2'h0;
         if (q_ff.main_cnt == 2'h0) begin                 // R14
            nxt_q.fail     = 1'b1;
            nxt_q.req      = 1'b1;
            nxt_q.use_rc   = 1'b1;
            nxt_q.stab     = 10'h0;
            nxt_q.fail_set = ~q_ff.fail;
         end else begin
            nxt_q.fail = 1'b0;
            if (q_ff.req) begin
               if (q_ff.stab == RC_STABLE_CYCLES - 10'h1) begin // R15
                  nxt_q.req    = 1'b0;
                  nxt_q.use_rc = 1'b0;
               end else begin
                  nxt_q.stab = q_ff.stab + 10'h1;
               end
            end
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_ff <= '{main_cnt: 2'h0, fail: 1'b1, req: 1'b1, use_rc: 1'b1,
                   stab: 10'h0, fail_set: 1'b0};
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign src_tick_o = q_ff.use_rc ? rc_tick_i : main_tick_i; // R14
   assign fail_o     = q_ff.fail;
   assign fail_set_o = q_ff.fail_set;
   assign owd_req_o  = q_ff.req;

   // ==========================================================
   // Checks
   property p_owd_hold_len;
      @(posedge clock_i) disable iff (!rst_n_i)
      $fell(q_ff.req) |-> $past(q_ff.stab) == RC_STABLE_CYCLES - 10'h1;
   endproperty
   a_owd_hold_len: assert property (p_owd_hold_len) // R15
      else $error("watchdog request dropped before hold count");

   property p_fail_uses_rc;
      @(posedge clock_i) disable iff (!rst_n_i)
      q_ff.fail |-> q_ff.use_rc && q_ff.req;
   endproperty
   a_fail_uses_rc: assert property (p_fail_uses_rc) // R14
      else $error("chip not clocked from RC during failure");

   c_owd_done: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      $fell(q_ff.req));
endmodule // rsq_osc_watchdog

// ### bench/rsq_reset_partner.sv
// Partner model: reset supervisor plus RC and main oscillator sources.
// Assumes a 100 MHz bench clock; both oscillators are derived from it.
module rsq_reset_partner (
   // Clock
   input  wire logic clock_i,
   // Bench controls
   input  wire logic hold_i,
   input  wire logic short_i,
   input  wire logic main_en_i,
   // Device pins
   output logic      reset_pin_n_o,
   output logic      rc_osc_o,
   output logic      main_osc_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Supervisor: low while asked, then MIN_LOW clocks more
   localparam int MIN_LOW = 288;
   int low_cnt_ff  = 0;
   int rc_cnt_ff   = 0;
   int main_cnt_ff = 0;
   always @(posedge clock_i) begin
      if (hold_i) begin
         low_cnt_ff <= 0;
      end else if (low_cnt_ff < MIN_LOW) begin
         low_cnt_ff <= low_cnt_ff + 1;
      end
   end
   // Low from power-up on; short_i breaks the minimum on purpose
   assign reset_pin_n_o = !(hold_i || low_cnt_ff < MIN_LOW || short_i);
   // ==========================================================
   // Oscillators: RC period 12 clocks, main period 4 clocks
   always @(posedge clock_i) begin
      rc_cnt_ff <= (rc_cnt_ff == 11) ? 0 : rc_cnt_ff + 1;
      if (main_en_i) begin
         main_cnt_ff <= (main_cnt_ff == 3) ? 0 : main_cnt_ff + 1;
      end
   end
   assign rc_osc_o   = rc_cnt_ff < 6;
   assign main_osc_o = main_en_i ? main_cnt_ff < 2 : 1'b0;
endmodule // rsq_reset_partner

// ### bench/reset_sync_poweron_sequencer_tb_top.sv
// Testbench top: power-on, release, port traffic, resets, osc failure.
// Assumes the sequencer top and the partner model in bench/.
module reset_sync_poweron_sequencer_tb_top import rsq_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Signals
   logic        clock_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        hold = 1'b1, short_p = 1'b0, main_en = 1'b0;
   logic        boot = 1'b0, hw_powerdown_input_n = 1'b1, ram_wr = 1'b0;
   logic [7:0]  p7 = 8'h00, p8 = 8'h00, wr_data = 8'h00;
   logic [6:0]  port_wr = 7'h00;
   wire logic   pin_n, rc_osc, main_osc;
   logic        int_rst, ro_n, run, fstart, aoe, bmode, ale, ale_oe;
   logic        pse_oe, ram_en, hw_powerdown_input, swx, flag, ofail;
   logic [15:0] faddr;
   logic [55:0] latch;
   logic [7:0]  rd7, rd8;
   int          n_fail = 0, n_checks = 0, seed = 37425, n = 0;
   int          lat[7];
   always #5 clock_i = ~clock_i;
   // ==========================================================
   // Instances
   rsq_reset_partner u_rsq_reset_partner (.clock_i(clock_i),
      .hold_i(hold), .short_i(short_p), .main_en_i(main_en),
      .reset_pin_n_o(pin_n), .rc_osc_o(rc_osc), .main_osc_o(main_osc));
   rsq_reset_seq u_rsq_reset_seq (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .reset_pin_n_i(pin_n), .boot_mode_select_i(boot),
      .hw_powerdown_input_n_i(hw_powerdown_input_n), .rc_osc_i(rc_osc),
      .main_osc_i(main_osc), .port7_pin_i(p7), .port8_pin_i(p8),
      .port_wr_i(port_wr), .port_wr_data_i(wr_data), .ram_wr_i(ram_wr),
      .internal_reset_o(int_rst), .reset_output_pin_n_o(ro_n),
      .run_o(run), .fetch_addr_o(faddr), .fetch_start_o(fstart),
      .addr_out_en_o(aoe), .boot_mode_o(bmode), .ale_o(ale),
      .ale_oe_o(ale_oe), .program_store_enable_oe_o(pse_oe),
      .port_latch_o(latch), .port7_rd_o(rd7), .port8_rd_o(rd8),
      .ram_wr_en_o(ram_en), .hw_powerdown_o(hw_powerdown_input),
      .sw_powerdown_exit_o(swx), .osc_watchdog_status_flag_o(flag),
      .osc_fail_o(ofail));
   // ==========================================================
   // Helpers
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [55:0] exp_lat();
      for (int i = 0; i < 7; i++) begin
         exp_lat[8*i +: 8] = lat[i][7:0];
      end
   endfunction
   task automatic cyc(input int k);
      repeat (k) @(negedge clock_i);
   endtask
   // Waits for 0 run, 1 reset, 2 osc failure, else fetch start
   task automatic wait_for(input int sel, input logic val, input int lim);
      logic s;
      n = 0;
      do begin
         @(negedge clock_i);
         n++;
         case (sel)
            0: s = run;
            1: s = int_rst;
            2: s = ofail;
            default: s = fstart;
         endcase
      end while (s !== val && n < lim);
   endtask
   task automatic release_run(input logic b);
      boot = b;
      hold = 1'b0;
      wait_for(3, 1'b1, 700);
      check(fstart, 1'b1);
      check(n >= 370 && n <= 490, 1'b1);
      check({faddr, bmode, ale, ale_oe, pse_oe, aoe},
            {RESET_VECTOR, b, 4'hf});
      check(latch, exp_lat());
      cyc(12);
      check({run, ale}, 2'h2);
      $display("release with boot level %0d done", b);
   endtask
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ==========================================================
   // Watchdog
   initial begin
      #600us;
      n_fail++;
      stop_test();
   end
   // ==========================================================
   // Tests
   initial begin
      int r;
      int j;
      foreach (lat[i]) lat[i] = 255;
      cyc(5);
      rst_n_i = 1'b1;
      // Power-on with the main oscillator silent
      cyc(150);
      check({int_rst, ofail, flag}, 3'h7);
      check(latch, exp_lat());
      check({ale_oe, pse_oe, ro_n}, 3'h0);
      hw_powerdown_input_n = 1'b0;
      main_en = 1'b1;
      wait_for(2, 1'b0, 100);
      check(ofail, 1'b0);
      cyc(int'(RC_STABLE_CYCLES) * 12 + 400);
      check({run, hw_powerdown_input, flag, int_rst}, 4'h1);
      hw_powerdown_input_n = 1'b1;
      release_run(1'b1);
      $display("power-on test done");
      // Port writes, input-only ports and RAM gate
      for (int k = 0; k < 40; k++) begin
         r = $random(seed);
         j = int'(r[2:0]) % 7;
         port_wr = 7'h01 << j;
         wr_data = r[15:8];
         p7 = r[23:16];
         p8 = r[31:24];
         ram_wr = r[4];
         lat[j] = int'(r[15:8]);
         @(negedge clock_i);
         port_wr = 7'h00;
         check(ram_en, r[4]);
         cyc(2);
         check(latch, exp_lat());
         check({rd7, rd8}, {p7, p8});
      end
      ram_wr = 1'b0;
      $display("port test done");
      // A single low sample does not reset
      short_p = 1'b1;
      cyc(40);
      short_p = 1'b0;
      cyc(150);
      check({run, int_rst}, 2'h2);
      $display("short pulse test done");
      // Reset in run ends power-down and restores latches
      hw_powerdown_input_n = 1'b0;
      cyc(4);
      check(hw_powerdown_input, 1'b1);
      hold = 1'b1;
      wait_for(1, 1'b1, 300);
      check(n >= 96 && n <= 200, 1'b1);
      port_wr = 7'h7f;
      wr_data = 8'h00;
      @(negedge clock_i);
      port_wr = 7'h00;
      cyc(200);
      foreach (lat[i]) lat[i] = 255;
      check(latch, exp_lat());
      check({run, ale_oe, pse_oe, aoe, hw_powerdown_input, swx, ro_n}, 7'h02);
      hw_powerdown_input_n = 1'b1;
      release_run(1'b0);
      $display("reset in run test done");
      // Main oscillator failure in run
      main_en = 1'b0;
      wait_for(2, 1'b1, 40);
      check(ofail, 1'b1);
      wait_for(1, 1'b1, 400);
      check({int_rst, run}, 2'h2);
      main_en = 1'b1;
      wait_for(2, 1'b0, 60);
      check(ofail, 1'b0);
      wait_for(0, 1'b1, 11000);
      check(n >= int'(RC_STABLE_CYCLES) * 12 - 16 &&
            n <= int'(RC_STABLE_CYCLES) * 12 + 320, 1'b1);
      check(flag, 1'b1);
      $display("oscillator failure test done");
      stop_test();
   end
endmodule // reset_sync_poweron_sequencer_tb_top
